// ---- verilog/ais_pkg.sv ----
// Shared constants, field layout and state types of the two-wire ADC setup front end
package ais_pkg;

   // Bit counting on the serial link
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_ONE  = 4'h1;
   localparam logic [3:0] BIT_CNT_LAST = 4'h8;

   // Address byte layout
   localparam int ADDR_HI  = 7;
   localparam int ADDR_LO  = 1;
   localparam int RW_BIT   = 0;
   localparam int HS_HI    = 7;
   localparam int HS_LO    = 3;
   localparam logic [4:0] HS_CODE_PREFIX = 5'h01;

   // Written byte layout, shared by the setup and the configuration byte
   localparam int REG_BIT     = 7;
   localparam int REF_SEL_HI  = 6;
   localparam int REF_SEL_LO  = 4;
   localparam int CLK_SEL_BIT = 3;
   localparam int POL_BIT     = 2;
   localparam int CFG_RST_BIT = 1;
   localparam int CFG_HI      = 6;
   localparam int CFG_LO      = 0;
   localparam int CS_HI       = 4;
   localparam int CS_LO       = 1;
   localparam int SCAN_LO     = 5;
   localparam int TX_NEXT_BIT = 6;

   // Power-up values
   localparam logic [2:0] REF_SEL_RESET = 3'h0;
   localparam logic       CLK_SEL_RESET = 1'b0;
   localparam logic       POL_RESET     = 1'b0;
   localparam logic [6:0] CFG_RESET     = 7'h01;

   // Result coding limits
   localparam logic [7:0]        UNI_ZERO  = 8'h00;
   localparam logic [7:0]        BIP_MAX   = 8'h7f;
   localparam logic [7:0]        BIP_MIN   = 8'h80;
   localparam logic signed [8:0] BIP_HI_9  = 9'sh07f;
   localparam logic signed [8:0] BIP_LO_9  = 9'sh180;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_MACK} ais_state_t;
   typedef enum logic [1:0] {ACK_RD, ACK_WR, ACK_DATA, ACK_HS} ais_ack_t;

endpackage

// ---- verilog/ais_sync.sv ----
// Two-stage synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none
module ais_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s1;
   } ais_sync_st_t;

   ais_sync_st_t st_q;
   ais_sync_st_t st_d;

   // First stage feeds only the second stage
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   // Idle bus lines rest high, so reset to ones
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_q <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;

endmodule // ais_sync
`default_nettype wire

// ---- verilog/ais_result_coder.sv ----
// Result coding for single-ended, unipolar and bipolar input modes
`timescale 1ns/1ps
`default_nettype none
module ais_result_coder
   import ais_pkg::*;
(
   input  wire logic       input_mode_select,
   input  wire logic       polarity_select,
   input  wire logic [7:0] sample_pos,
   input  wire logic [7:0] sample_neg,
   output logic      [7:0] result
);
   logic signed [8:0] diff;

   // Difference of the two inputs, then clamp to the range of the mode
   always_comb begin
      diff = $signed({1'b0, sample_pos}) - $signed({1'b0, sample_neg});
      if (input_mode_select) begin
         result = sample_pos;
      end else if (!polarity_select) begin
         result = diff[8] ? UNI_ZERO : diff[7:0];
      end else if (diff > BIP_HI_9) begin
         // two's complement, saturating at half scale
         result = BIP_MAX;
      end else if (diff < BIP_LO_9) begin
         result = BIP_MIN;
      end else begin
         result = diff[7:0];
      end
   end

endmodule // ais_result_coder
`default_nettype wire

// ---- verilog/ais_slave.sv ----
// Two-wire slave front end with setup byte decode for a multichannel 8-bit ADC
//
// Operation
// - Setup bits 6..4 select reference and shared pin; power-up 000.
// - Setup bit 1 low restores configuration defaults; high does nothing; bit 0 ignored.
// - Setup bit 2 picks unipolar (0) or bipolar (1) in pseudo-differential mode.
// - Single-ended mode: result is selected channel against ground.
// - Pseudo-differential mode: result is positive minus negative input of pair.
// - Unipolar: straight binary, negative difference gives all zeros.
// - Bipolar: two's complement over plus or minus half reference.
// - Single-ended mode always codes unipolar, ignoring polarity bit.
// - Nine clocks per byte; data stable while clock high except start/stop.
// - Both lines released high while the bus is idle.
// - Repeated start keeps bus active and timing mode unchanged.
// - Receiver acknowledges low through ninth clock high; not-acknowledge leaves high.
// - Idle device watches for start plus own fixed address, ignores others.
// - Last address bit: zero master writes, one master reads.
// - Matching address is acknowledged low for one clock.
// - Power-up uses fast/standard timing; high-speed needed for top rates.
// - Conversion clock select defaults zero internal, one uses bus clock.
// - Master code 00001xxx is not acknowledged, enters high-speed; stop leaves.
`timescale 1ns/1ps
`default_nettype none
module ais_slave
   import ais_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary value, set per product
) (
   input  wire logic       REF_CLK,
   input  wire logic       RST_B,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE,
   input  wire logic [7:0] SAMPLE_POS,
   input  wire logic [7:0] SAMPLE_NEG,
   output logic [2:0]      REFERENCE_SELECT,
   output logic            CONV_CLOCK_SELECT,
   output logic            POLARITY_SELECT,
   output logic            INPUT_MODE_SELECT,
   output logic [3:0]      CHANNEL_SELECT,
   output logic [1:0]      SCAN_SELECT,
   output logic            HS_MODE,
   output logic            BUS_BUSY,
   output logic [7:0]      RESULT_CODE
);
   typedef struct packed {
      ais_state_t state;
      ais_ack_t   kind;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic       scl_p;
      logic       sda_p;
      logic       sda_o;
      logic       sda_oe;
      logic       hs;
      logic       busy;
      logic [2:0] ref_sel;
      logic       clk_sel;
      logic       pol;
      logic [6:0] cfg;
      logic [7:0] result;
   } ais_st_t;

   ais_st_t    q;
   ais_st_t    d;
   logic [1:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_w;
   logic       stop_w;
   logic       setup_load;
   logic       cfg_rst;
   logic       hs_set;
   logic [7:0] result_w;

   // Bus pins come from another domain, so two flops before any use
   ais_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .d     ({SCL_I, SDA_I}),
      .q     (pins_s)
   );

   ais_result_coder u_coder (
      .input_mode_select (q.cfg[CFG_LO]),
      .polarity_select   (q.pol),
      .sample_pos        (SAMPLE_POS),
      .sample_neg        (SAMPLE_NEG),
      .result            (result_w)
   );

   // Edges of the synchronised lines
   assign scl_s    = pins_s[1];
   assign sda_s    = pins_s[0];
   assign scl_rise = scl_s && !q.scl_p;
   assign scl_fall = !scl_s && q.scl_p;
   // data edges while clock high frame a transfer
   assign start_w  = scl_s && q.scl_p && q.sda_p && !sda_s;
   assign stop_w   = scl_s && q.scl_p && !q.sda_p && sda_s;

   // Next-state logic; the device only moves data on clock falls so the
   // line stays put through every high phase
   always_comb begin
      d          = q;
      setup_load = 1'b0;
      cfg_rst    = 1'b0;
      hs_set     = 1'b0;
      d.scl_p    = scl_s;
      d.sda_p    = sda_s;
      d.result   = result_w;
      if (start_w) begin
         // repeated start leaves the timing mode alone
         d.state  = ST_ADDR;
         d.cnt    = BIT_CNT_ZERO;
         d.sda_oe = 1'b0;
         d.busy   = 1'b1;
      end else if (stop_w) begin
         d.state  = ST_IDLE;
         d.sda_oe = 1'b0;
         d.hs     = 1'b0;
         d.busy   = 1'b0;
      end else if (scl_rise) begin
         unique case (q.state)
            ST_ADDR, ST_WRITE: begin
               d.shreg = {q.shreg[TX_NEXT_BIT:0], sda_s};
               d.cnt   = q.cnt + BIT_CNT_ONE;
            end
            ST_READ: begin
               d.cnt = q.cnt + BIT_CNT_ONE;
            end
            ST_MACK: begin
               // master not-acknowledge ends the read, line stays free
               if (sda_s) begin
                  d.state = ST_IDLE;
               end else begin
                  d.state = ST_ACK;
                  d.kind  = ACK_RD;
               end
            end
            ST_IDLE, ST_ACK: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (q.state)
            ST_ADDR: begin
               if (q.cnt == BIT_CNT_LAST) begin
                  if (q.shreg[ADDR_HI:ADDR_LO] == DEV_ADDR) begin
                     // drive the acknowledge for the ninth clock
                     d.state  = ST_ACK;
                     d.sda_oe = 1'b1;
                     // direction from the last address bit
                     d.kind   = q.shreg[RW_BIT] ? ACK_RD : ACK_WR;
                  end else if (q.shreg[HS_HI:HS_LO] == HS_CODE_PREFIX) begin
                     d.state = ST_ACK;
                     d.kind  = ACK_HS;
                  end else begin
                     d.state = ST_IDLE;
                  end
               end
            end
            ST_WRITE: begin
               if (q.cnt == BIT_CNT_LAST) begin
                  d.state  = ST_ACK;
                  d.kind   = ACK_DATA;
                  d.sda_oe = 1'b1;
               end
            end
            ST_ACK: begin
               d.sda_oe = 1'b0;
               d.cnt    = BIT_CNT_ZERO;
               unique case (q.kind)
                  ACK_RD: begin
                     // Present the result MSB right after the slot
                     d.state  = ST_READ;
                     d.shreg  = q.result;
                     d.sda_oe = !q.result[REG_BIT];
                  end
                  ACK_WR: begin
                     d.state = ST_WRITE;
                  end
                  ACK_DATA: begin
                     d.state = ST_WRITE;
                     // bit 7 tells setup from configuration
                     if (q.shreg[REG_BIT]) begin
                        // load only once the byte was acknowledged
                        setup_load = 1'b1;
                        d.ref_sel  = q.shreg[REF_SEL_HI:REF_SEL_LO];
                        d.clk_sel  = q.shreg[CLK_SEL_BIT];
                        d.pol      = q.shreg[POL_BIT];
                        // low bit 1 resets configuration only
                        if (!q.shreg[CFG_RST_BIT]) begin
                           cfg_rst = 1'b1;
                           d.cfg   = CFG_RESET;
                        end
                     end else begin
                        d.cfg = q.shreg[CFG_HI:CFG_LO];
                     end
                  end
                  ACK_HS: begin
                     hs_set  = 1'b1;
                     d.hs    = 1'b1;
                     d.state = ST_IDLE;
                  end
               endcase
            end
            ST_READ: begin
               if (q.cnt == BIT_CNT_LAST) begin
                  // Release for the master's acknowledge
                  d.state  = ST_MACK;
                  d.sda_oe = 1'b0;
               end else begin
                  d.shreg  = {q.shreg[TX_NEXT_BIT:0], 1'b0};
                  d.sda_oe = !q.shreg[TX_NEXT_BIT];
               end
            end
            ST_IDLE, ST_MACK: begin
            end
         endcase
      end
   end

   // State register; power-up in fast/standard timing
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         q         <= '0;
         q.state   <= ST_IDLE;
         q.kind    <= ACK_WR;
         q.scl_p   <= 1'b1;
         q.sda_p   <= 1'b1;
         q.ref_sel <= REF_SEL_RESET;
         q.clk_sel <= CLK_SEL_RESET;
         q.pol     <= POL_RESET;
         q.cfg     <= CFG_RESET;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign SDA_O             = q.sda_o;  // Open drain: only ever pulls low
   assign SDA_OE            = q.sda_oe;
   assign REFERENCE_SELECT  = q.ref_sel;
   assign CONV_CLOCK_SELECT = q.clk_sel;
   assign POLARITY_SELECT   = q.pol;
   // zero selects pseudo-differential pairs in the coder
   assign INPUT_MODE_SELECT = q.cfg[CFG_LO];
   assign CHANNEL_SELECT    = q.cfg[CS_HI:CS_LO];
   assign SCAN_SELECT       = q.cfg[CFG_HI:SCAN_LO];
   assign HS_MODE           = q.hs;
   assign BUS_BUSY          = q.busy;
   assign RESULT_CODE       = q.result;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);

   a_setup_load_only: assert property (
      $changed(REFERENCE_SELECT) |-> $past(setup_load))
      else $error("reference select changed without a setup load");

   a_cfg_reset_val: assert property (
      cfg_rst |=> ({SCAN_SELECT, CHANNEL_SELECT, INPUT_MODE_SELECT} == CFG_RESET)
                  && (REFERENCE_SELECT == $past(q.shreg[REF_SEL_HI:REF_SEL_LO])))
      else $error("configuration reset wrong or setup disturbed");

   a_single_ended_code: assert property (
      INPUT_MODE_SELECT |-> result_w == SAMPLE_POS)
      else $error("single-ended result not ground referenced");

   a_unipolar_clamp: assert property (
      !INPUT_MODE_SELECT && !POLARITY_SELECT && (SAMPLE_POS < SAMPLE_NEG)
      |-> result_w == UNI_ZERO)
      else $error("negative unipolar input not clamped to zero");

   a_bipolar_code: assert property (
      !INPUT_MODE_SELECT && POLARITY_SELECT && (SAMPLE_POS >= SAMPLE_NEG)
      && (SAMPLE_POS - SAMPLE_NEG <= BIP_MAX) |-> result_w == SAMPLE_POS - SAMPLE_NEG)
      else $error("bipolar result not the input difference");

   a_idle_released: assert property (
      q.state == ST_IDLE |-> !SDA_OE)
      else $error("data line driven while idle");

   a_sda_high_stable: assert property (
      $changed(SDA_OE) |-> $past(scl_fall) || $past(start_w) || $past(stop_w))
      else $error("data line moved outside a clock low phase");

   a_ack_drive: assert property (
      scl_rise && q.state == ST_ACK && q.kind != ACK_HS |-> SDA_OE)
      else $error("acknowledge not driven at the ninth clock");

   a_hs_entry: assert property (
      hs_set |-> !SDA_OE ##1 HS_MODE)
      else $error("master code acknowledged or high-speed not entered");

   a_stop_leaves_hs: assert property (
      stop_w |=> !HS_MODE && !BUS_BUSY)
      else $error("stop did not return to fast/standard timing");

   a_rstart_keeps_hs: assert property (
      start_w |=> HS_MODE == $past(HS_MODE) && BUS_BUSY)
      else $error("start changed the timing mode");

   a_foreign_addr: assert property (
      scl_fall && q.state == ST_ADDR && q.cnt == BIT_CNT_LAST
      && q.shreg[ADDR_HI:ADDR_LO] != DEV_ADDR && q.shreg[HS_HI:HS_LO] != HS_CODE_PREFIX
      |=> q.state == ST_IDLE && !SDA_OE)
      else $error("foreign address not ignored");

   a_read_dir: assert property (
      scl_fall && q.state == ST_ACK && q.kind == ACK_RD |=> q.state == ST_READ)
      else $error("read address did not start a read");

   a_write_ack: assert property (
      scl_fall && q.state == ST_WRITE && q.cnt == BIT_CNT_LAST |=> SDA_OE && q.state == ST_ACK)
      else $error("written byte not acknowledged");

   a_mack_release: assert property (
      q.state == ST_MACK |-> !SDA_OE)
      else $error("data line held during the master acknowledge slot");

   a_hs_nack: assert property (
      q.state == ST_ACK && q.kind == ACK_HS |-> !SDA_OE)
      else $error("master code was acknowledged");

endmodule // ais_slave
`default_nettype wire

// ---- verif/ais_bus_master.sv ----
// Bus master model that drives the clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module ais_bus_master (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe
);
   // clock stands high, data released while idle
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   // Changes land just after a system clock edge, never on it
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // start, or repeated start from a low clock
   task automatic start();
      if (!scl) begin
         tick(5);
         sda_oe = 1'b0;
         tick(5);
         scl = 1'b1;
      end
      tick(5);
      sda_oe = 1'b1;
      tick(5);
      scl = 1'b0;
   endtask

   // stop: data rises while the clock is high
   task automatic stop();
      tick(5);
      sda_oe = 1'b1;
      tick(5);
      scl = 1'b1;
      tick(5);
      sda_oe = 1'b0;
      tick(10);
   endtask

   // data moves mid low phase, sampled mid high phase
   task automatic xbit(input logic b, output logic r);
      tick(5);
      sda_oe = !b;
      tick(5);
      scl = 1'b1;
      tick(5);
      r = sda;
      tick(5);
      scl = 1'b0;
   endtask

   // ninth clock carries the receiver's acknowledge
   task automatic xbyte(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r);
         q[i] = r;
      end
      xbit(!mack, r);
      ack = !r;
   endtask
endmodule // ais_bus_master
`default_nettype wire

// ---- verif/ais_slave_test.sv ----
// Self-checking bench for the two-wire ADC setup front end
`timescale 1ns/1ps
`default_nettype none
module ais_slave_test;
   import ais_pkg::*;
   localparam logic [6:0] ADDR = 7'h2a; // Arbitrary device address
   logic       ref_clk = 1'b0;
   logic       rst_b   = 1'b0;
   logic [7:0] pos     = 8'h00;
   logic [7:0] neg     = 8'h00;
   logic       scl, m_oe, sda_oe, sda_o, hs, busy, conv, pol, mode;
   logic [7:0] res;
   logic [2:0] refsel;
   logic [3:0] chan;
   logic [1:0] scan;
   wire logic  sda;
   int         num_errors = 0;
   int         compares   = 0;

   // Open-drain line with pull-up: low while either party pulls
   assign sda = !(sda_oe | m_oe);
   always #4 ref_clk = !ref_clk;

   ais_slave #(.DEV_ADDR(ADDR)) ais_slave_inst (
      .REF_CLK(ref_clk), .RST_B(rst_b), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .SAMPLE_POS(pos), .SAMPLE_NEG(neg),
      .REFERENCE_SELECT(refsel), .CONV_CLOCK_SELECT(conv),
      .POLARITY_SELECT(pol), .INPUT_MODE_SELECT(mode),
      .CHANNEL_SELECT(chan), .SCAN_SELECT(scan), .HS_MODE(hs),
      .BUS_BUSY(busy), .RESULT_CODE(res));

   ais_bus_master ais_bus_master_inst (
      .clk(ref_clk), .sda(sda), .scl(scl), .sda_oe(m_oe));

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Setup image keeps bits 6..2 in place, config image bits 6..0
   task automatic chk_regs(input logic [7:0] s, input logic [7:0] c);
      chk("setup", s, {1'b0, refsel, conv, pol, 2'b00});
      chk("config", c, {1'b0, scan, chan, mode});
   endtask

   task automatic wr(input logic [7:0] d, input logic ack, input string what);
      logic [7:0] q;
      logic       a;
      ais_bus_master_inst.xbyte(d, 1'b0, q, a);
      chk(what, {7'h00, ack}, {7'h00, a});
   endtask

   // One write transfer of a single byte
   task automatic wcyc(input logic [7:0] d);
      ais_bus_master_inst.start();
      wr({ADDR, 1'b0}, 1'b1, "addr ack");
      wr(d, 1'b1, "data ack");
      ais_bus_master_inst.stop();
   endtask

   // Read two bytes, acknowledging the first, refusing the second
   task automatic rd(input logic [7:0] exp, input string what);
      logic [7:0] q;
      logic       a;
      ais_bus_master_inst.start();
      wr({ADDR, 1'b1}, 1'b1, "read addr ack");
      chk(what, exp, res);
      ais_bus_master_inst.xbyte(8'hff, 1'b1, q, a);
      chk(what, exp, q);
      ais_bus_master_inst.xbyte(8'hff, 1'b0, q, a);
      chk(what, exp, q);
      ais_bus_master_inst.stop();
   endtask

   task automatic t_reset();
      chk_regs(8'h00, 8'h01);
      chk("hs mode", 8'h00, {7'h00, hs});
      chk("idle", 8'h00, {5'h00, sda_o, busy, sda_oe});
      $display("test reset done");
   endtask

   task automatic t_address();
      ais_bus_master_inst.start();
      wr({ADDR ^ 7'h01, 1'b0}, 1'b0, "foreign ack");
      wr(8'hfe, 1'b0, "ignored byte");
      ais_bus_master_inst.stop();
      chk_regs(8'h00, 8'h01);
      ais_bus_master_inst.start();
      wr({ADDR, 1'b0}, 1'b1, "retry ack");
      chk("busy", 8'h01, {7'h00, busy});
      wr(8'h9e, 1'b1, "setup ack");
      ais_bus_master_inst.stop();
      chk_regs(8'h1c, 8'h01);
      chk("idle", 8'h00, {6'h00, busy, sda_oe});
      $display("test address done");
   endtask

   task automatic t_bytes();
      logic r;
      ais_bus_master_inst.start();
      wr({ADDR, 1'b0}, 1'b1, "addr ack");
      wr(8'h2c, 1'b1, "config ack");
      wr(8'hf3, 1'b1, "setup ack");
      ais_bus_master_inst.stop();
      chk_regs(8'h70, 8'h2c);
      wcyc(8'hd4);
      chk_regs(8'h54, 8'h01);
      // Setup byte cut short by a stop must not load
      ais_bus_master_inst.start();
      wr({ADDR, 1'b0}, 1'b1, "addr ack");
      for (int i = 0; i < 4; i++) begin
         ais_bus_master_inst.xbit(1'b1, r);
      end
      ais_bus_master_inst.stop();
      chk_regs(8'h54, 8'h01);
      $display("test bytes done");
   endtask

   task automatic t_results();
      pos = 8'hc8;
      neg = 8'h30;
      rd(8'hc8, "single ended");
      wcyc(8'h00);
      pos = 8'h30;
      neg = 8'h50;
      rd(8'he0, "bipolar neg");
      pos = 8'h40;
      neg = 8'h10;
      rd(8'h30, "bipolar pos");
      wcyc(8'h8a);
      chk_regs(8'h08, 8'h00);
      rd(8'h30, "unipolar pos");
      pos = 8'h10;
      neg = 8'h50;
      rd(8'h00, "unipolar neg");
      $display("test results done");
   endtask

   task automatic t_speed();
      ais_bus_master_inst.start();
      wr(8'h08, 1'b0, "master code nack");
      ais_bus_master_inst.tick(6);
      chk("hs mode", 8'h01, {7'h00, hs});
      ais_bus_master_inst.start();
      chk("hs mode", 8'h01, {7'h00, hs});
      wr({ADDR, 1'b0}, 1'b1, "addr ack");
      wr(8'hf2, 1'b1, "setup ack");
      ais_bus_master_inst.stop();
      chk("hs mode", 8'h00, {7'h00, hs});
      chk_regs(8'h70, 8'h00);
      $display("test speed done");
   endtask

   task automatic end_of_test();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Reset for four cycles, then the scenarios in order
   initial begin
      repeat (4) @(posedge ref_clk);
      #1;
      rst_b = 1'b1;
      ais_bus_master_inst.tick(4);
      t_reset();
      t_address();
      t_bytes();
      t_results();
      t_speed();
      end_of_test();
   end

   // Scenarios need under 10k cycles; four times that means a hang
   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule // ais_slave_test
`default_nettype wire
